/* rtl/uff_pkg.sv */
// package: shared constants and types for the upstream frame fragmenter
package uff_pkg;
   // ====================================================
   // widths
   localparam int LEN_W = 16;
   localparam int SID_W = 4;
   localparam int SEQ_W = 4;
   localparam int RTY_W = 4;
   localparam int REQ_W = 8;
   localparam int TMR_W = 16;
   // ====================================================
   // overhead and sizing
   localparam logic [LEN_W-1:0] FRAG_OVH = 16'h0010; // header + header check + crc
   localparam logic [LEN_W-1:0] PHY_OVH_DEF = 16'h0008;
   localparam logic [LEN_W-1:0] MSLOT_BYTES_DEF = 16'h0010;
   localparam logic [RTY_W-1:0] RETRY_MAX_DEF = 4'h8;
   // ack time in ns and derived cycle count at 100 MHz (longest time: rounds down)
   localparam int ACK_TIME_NS = 20000;
   localparam int CLK_PERIOD_NS = 10;
   localparam int ACK_CYC = ACK_TIME_NS / CLK_PERIOD_NS;
   localparam logic [TMR_W-1:0] BACKOFF_CYC = 16'h0040;
   // header flag positions in the flag output
   localparam int FLG_FIRST = 1;
   localparam int FLG_LAST = 0;
   // ====================================================
   // fragmenter states
   typedef enum logic [2:0] {
      UFF_IDLE = 3'b000,
      UFF_REQ = 3'b001,
      UFF_WAIT = 3'b010,
      UFF_SEND = 3'b011,
      UFF_BACKOFF = 3'b100
   } uff_state_t;
endpackage

/* rtl/uff_fifo.sv */
// fifo holding fragment payload bytes on their way to the upstream transmitter
`timescale 1ns/10ps
module uff_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   // flush drops everything stored
   input wire logic flush
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [WIDTH-1:0] dout_r, dout_nxt;
   logic dv_r, dv_nxt;
   logic do_wr, do_rd, empty;

   // ====================================================
   // pointers; read data held in a register slot in front of memory
   always_comb begin
      empty = (wp_r == rp_r);
      in_ready = !((wp_r[AW-1:0] == rp_r[AW-1:0]) && (wp_r[AW] != rp_r[AW]));
      do_wr = in_valid && in_ready && !flush;
      do_rd = !empty && (!dv_r || out_ready) && !flush;
      wp_nxt = flush ? '0 : wp_r + (AW+1)'(do_wr);
      rp_nxt = flush ? '0 : rp_r + (AW+1)'(do_rd);
      dv_nxt = flush ? 1'b0 : (do_rd ? 1'b1 : (out_ready ? 1'b0 : dv_r));
      dout_nxt = do_rd ? mem_r[rp_r[AW-1:0]] : dout_r;
      out_valid = dv_r;
      out_data = dout_r;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_r <= '0;
         rp_r <= '0;
         dv_r <= 1'b0;
         dout_r <= '0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         dv_r <= dv_nxt;
         dout_r <= dout_nxt;
      end
   end

   // storage has no reset so it maps to plain ram
   always_ff @(posedge sys_clk) begin
      if (do_wr) begin
         mem_r[wp_r[AW-1:0]] <= in_data;
      end
   end
endmodule

/* rtl/uff_fragmenter.sv */
// upstream frame fragmenter: cuts queued frames into fragments to fit partial grants
`timescale 1ns/10ps
module uff_fragmenter
   import uff_pkg::*;
#(
   parameter int NSID = 1 << uff_pkg::SID_W,
   parameter int ACK_CYCLES = uff_pkg::ACK_CYC,
   parameter int FIFO_DEPTH = 8
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // configuration
   input wire logic frag_en_modem,
   input wire logic [NSID-1:0] frag_en_flow,
   input wire logic [uff_pkg::LEN_W-1:0] phy_ovh,
   input wire logic [uff_pkg::LEN_W-1:0] mslot_bytes,
   input wire logic [uff_pkg::RTY_W-1:0] retry_max,
   // frame offered by the queue (one frame at a time)
   input wire logic frame_valid,
   input wire logic [uff_pkg::SID_W-1:0] frame_sid,
   input wire logic [uff_pkg::LEN_W-1:0] frame_len,
   input wire logic frame_immediate,
   input wire logic next_frame_pending,
   input wire logic [uff_pkg::LEN_W-1:0] next_frame_len,
   output logic frame_done,
   output logic frame_dropped,
   // allocation map events
   input wire logic map_valid,
   input wire logic [uff_pkg::SID_W-1:0] map_sid,
   input wire logic [uff_pkg::LEN_W-1:0] grant_bytes,
   input wire logic grant_pending,
   input wire logic later_grant_queued,
   // payload bytes from the frame store
   input wire logic pay_valid,
   input wire logic [7:0] pay_data,
   output logic pay_ready,
   // request channel to the contention/request path
   output logic req_valid,
   output logic [uff_pkg::SID_W-1:0] req_sid,
   output logic [uff_pkg::REQ_W-1:0] req_mslots,
   // fragment header descriptor toward the transmitter
   output logic hdr_valid,
   output logic [uff_pkg::SID_W-1:0] hdr_sid,
   output logic [1:0] hdr_flags,
   output logic [uff_pkg::SEQ_W-1:0] hdr_seq,
   output logic [uff_pkg::REQ_W-1:0] hdr_piggyback,
   output logic [uff_pkg::LEN_W-1:0] hdr_payload_len,
   output logic hdr_fragmented,
   output logic [uff_pkg::LEN_W-1:0] crypt_start,
   // payload bytes toward the transmitter
   output logic tx_valid,
   output logic [7:0] tx_data,
   input wire logic tx_ready
);
   import uff_pkg::*;

   // ====================================================
   // helpers
   // bytes to mini-slots, rounded up
   function automatic logic [REQ_W-1:0] to_mslots(input logic [LEN_W-1:0] bytes,
                                                  input logic [LEN_W-1:0] msb);
      logic [LEN_W-1:0] q;
      q = (msb == '0) ? bytes : (bytes + msb - 16'h0001) / msb;
      to_mslots = (q > 16'h00ff) ? 8'hff : q[REQ_W-1:0];
   endfunction

   // ====================================================
   // per-flow state (sequence numbers and in-progress flag)
   logic [SEQ_W-1:0] seq_r [NSID];
   logic [SEQ_W-1:0] seq_nxt [NSID];
   logic [NSID-1:0] infrag_r, infrag_nxt;

   // ====================================================
   // transfer state
   uff_state_t st_r, st_nxt;
   logic [LEN_W-1:0] remain_r, remain_nxt; // untransmitted payload bytes
   logic [LEN_W-1:0] send_r, send_nxt; // bytes left to move this grant
   logic [SID_W-1:0] sid_r, sid_nxt;
   logic [RTY_W-1:0] rty_r, rty_nxt;
   logic [TMR_W-1:0] tmr_r, tmr_nxt;
   logic req_valid_r, req_valid_nxt;
   logic [REQ_W-1:0] req_mslots_r, req_mslots_nxt;
   logic hdr_valid_r, hdr_valid_nxt;
   logic [1:0] hdr_flags_r, hdr_flags_nxt;
   logic [SEQ_W-1:0] hdr_seq_r, hdr_seq_nxt;
   logic [REQ_W-1:0] hdr_pb_r, hdr_pb_nxt;
   logic [LEN_W-1:0] hdr_len_r, hdr_len_nxt;
   logic hdr_frag_r, hdr_frag_nxt;
   logic [LEN_W-1:0] crypt_r, crypt_nxt;
   logic done_r, done_nxt, drop_r, drop_nxt, flush_r, flush_nxt;
   logic fifo_in_ready;
   logic [LEN_W-1:0] fit, rem_after, full_need;
   logic grant_hit, moving;

   always_comb begin
      st_nxt = st_r;
      remain_nxt = remain_r;
      send_nxt = send_r;
      sid_nxt = sid_r;
      rty_nxt = rty_r;
      tmr_nxt = tmr_r;
      infrag_nxt = infrag_r;
      seq_nxt = seq_r;
      req_valid_nxt = 1'b0;
      req_mslots_nxt = req_mslots_r;
      hdr_valid_nxt = 1'b0;
      hdr_flags_nxt = hdr_flags_r;
      hdr_seq_nxt = hdr_seq_r;
      hdr_pb_nxt = hdr_pb_r;
      hdr_len_nxt = hdr_len_r;
      hdr_frag_nxt = hdr_frag_r;
      crypt_nxt = crypt_r;
      done_nxt = 1'b0;
      drop_nxt = 1'b0;
      flush_nxt = 1'b0;
      grant_hit = map_valid && (map_sid == sid_r);
      // payload that fits after fragment and phy overhead
      fit = (grant_bytes > FRAG_OVH + phy_ovh) ? grant_bytes - FRAG_OVH - phy_ovh : '0;
      full_need = remain_r + phy_ovh;
      rem_after = (remain_r > fit) ? remain_r - fit : '0;
      moving = (send_r != '0) && pay_valid && fifo_in_ready;
      pay_ready = (st_r == UFF_SEND) && (send_r != '0) && fifo_in_ready;
      case (st_r)
         UFF_IDLE: begin
            if (frame_valid) begin
               sid_nxt = frame_sid;
               remain_nxt = frame_len;
               rty_nxt = '0;
               st_nxt = UFF_REQ;
            end
         end
         UFF_REQ: begin
            // remainder request carries the fragment overhead once fragmented
            req_valid_nxt = 1'b1;
            req_mslots_nxt = to_mslots(infrag_r[sid_r] ? remain_r + FRAG_OVH + phy_ovh : full_need,
                                       mslot_bytes);
            tmr_nxt = TMR_W'(ACK_CYCLES);
            st_nxt = UFF_WAIT;
         end
         UFF_WAIT: begin
            tmr_nxt = tmr_r - 16'h0001;
            if (grant_hit && grant_bytes != '0) begin
               rty_nxt = '0;
               // partial grant on an enabled flow starts or continues fragmentation
               if (frag_en_modem && frag_en_flow[sid_r] && !frame_immediate &&
                   (infrag_r[sid_r] ? remain_r + FRAG_OVH + phy_ovh > grant_bytes
                                    : full_need > grant_bytes) && fit != '0) begin
                  hdr_frag_nxt = 1'b1;
                  hdr_len_nxt = (remain_r > fit) ? fit : remain_r;
                  // flags by position within the frame
                  hdr_flags_nxt[FLG_FIRST] = !infrag_r[sid_r] && (rem_after != '0);
                  hdr_flags_nxt[FLG_LAST] = infrag_r[sid_r] && (rem_after == '0);
                  hdr_seq_nxt = seq_r[sid_r];
                  seq_nxt[sid_r] = seq_r[sid_r] + 4'h1;
                  infrag_nxt[sid_r] = (rem_after != '0);
                  // piggyback only when nothing later is known for this flow
                  if (grant_pending || later_grant_queued) begin
                     hdr_pb_nxt = '0;
                  end else if (rem_after != '0) begin
                     hdr_pb_nxt = to_mslots(rem_after + FRAG_OVH + phy_ovh, mslot_bytes);
                  end else begin
                     hdr_pb_nxt = next_frame_pending ? to_mslots(next_frame_len + phy_ovh, mslot_bytes) : '0;
                  end
                  crypt_nxt = '0; // encryption starts just after the header check, through the crc
                  send_nxt = hdr_len_nxt;
                  remain_nxt = rem_after;
               end else if (grant_bytes >= (infrag_r[sid_r] ? remain_r + FRAG_OVH + phy_ovh : full_need)) begin
                  // whole remainder fits
                  hdr_frag_nxt = infrag_r[sid_r];
                  hdr_flags_nxt = infrag_r[sid_r] ? 2'h1 : 2'h0;
                  hdr_seq_nxt = seq_r[sid_r];
                  if (infrag_r[sid_r]) begin
                     seq_nxt[sid_r] = seq_r[sid_r] + 4'h1;
                  end
                  infrag_nxt[sid_r] = 1'b0;
                  hdr_len_nxt = remain_r;
                  hdr_pb_nxt = (grant_pending || later_grant_queued || !next_frame_pending) ? '0
                               : to_mslots(next_frame_len + phy_ovh, mslot_bytes);
                  crypt_nxt = '0;
                  send_nxt = remain_r;
                  remain_nxt = '0;
               end
               hdr_valid_nxt = (send_nxt != '0);
               st_nxt = (send_nxt != '0) ? UFF_SEND : UFF_WAIT;
            end else if (grant_hit && grant_pending) begin
               tmr_nxt = TMR_W'(ACK_CYCLES); // pending keeps the wait alive
            end else if (tmr_r == '0) begin
               // ack time lapsed with no grant or pending
               if (rty_r >= retry_max) begin
                  drop_nxt = 1'b1;
                  flush_nxt = 1'b1;
                  infrag_nxt[sid_r] = 1'b0;
                  st_nxt = UFF_IDLE;
               end else begin
                  rty_nxt = rty_r + 4'h1;
                  tmr_nxt = BACKOFF_CYC;
                  st_nxt = UFF_BACKOFF;
               end
            end
         end
         UFF_BACKOFF: begin
            tmr_nxt = tmr_r - 16'h0001;
            if (tmr_r == '0) begin
               st_nxt = UFF_REQ;
            end
         end
         UFF_SEND: begin
            if (moving) begin
               send_nxt = send_r - 16'h0001;
            end
            if (send_nxt == '0) begin
               if (remain_r == '0) begin
                  done_nxt = 1'b1;
                  st_nxt = UFF_IDLE;
               end else begin
                  // wait for next grant; piggyback or pending covers the request
                  tmr_nxt = TMR_W'(ACK_CYCLES);
                  st_nxt = UFF_WAIT;
               end
            end
         end
         default: st_nxt = UFF_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= UFF_IDLE;
         remain_r <= '0;
         send_r <= '0;
         sid_r <= '0;
         rty_r <= '0;
         tmr_r <= '0;
         infrag_r <= '0;
         for (int i = 0; i < NSID; i++) begin
            seq_r[i] <= '0;
         end
         req_valid_r <= 1'b0;
         req_mslots_r <= '0;
         hdr_valid_r <= 1'b0;
         hdr_flags_r <= '0;
         hdr_seq_r <= '0;
         hdr_pb_r <= '0;
         hdr_len_r <= '0;
         hdr_frag_r <= 1'b0;
         crypt_r <= '0;
         done_r <= 1'b0;
         drop_r <= 1'b0;
         flush_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         remain_r <= remain_nxt;
         send_r <= send_nxt;
         sid_r <= sid_nxt;
         rty_r <= rty_nxt;
         tmr_r <= tmr_nxt;
         infrag_r <= infrag_nxt;
         seq_r <= seq_nxt;
         req_valid_r <= req_valid_nxt;
         req_mslots_r <= req_mslots_nxt;
         hdr_valid_r <= hdr_valid_nxt;
         hdr_flags_r <= hdr_flags_nxt;
         hdr_seq_r <= hdr_seq_nxt;
         hdr_pb_r <= hdr_pb_nxt;
         hdr_len_r <= hdr_len_nxt;
         hdr_frag_r <= hdr_frag_nxt;
         crypt_r <= crypt_nxt;
         done_r <= done_nxt;
         drop_r <= drop_nxt;
         flush_r <= flush_nxt;
      end
   end

   // ====================================================
   // output wiring, all from flip-flops
   assign req_valid = req_valid_r;
   assign req_sid = sid_r;
   assign req_mslots = req_mslots_r;
   assign hdr_valid = hdr_valid_r;
   assign hdr_sid = sid_r;
   assign hdr_flags = hdr_flags_r;
   assign hdr_seq = hdr_seq_r;
   assign hdr_piggyback = hdr_pb_r;
   assign hdr_payload_len = hdr_len_r;
   assign hdr_fragmented = hdr_frag_r;
   assign crypt_start = crypt_r;
   assign frame_done = done_r;
   assign frame_dropped = drop_r;

   // ====================================================
   // payload buffer; a stalled transmitter back-pressures the frame store
   uff_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .in_valid(pay_valid && (st_r == UFF_SEND) && (send_r != '0)),
      .in_ready(fifo_in_ready),
      .in_data(pay_data),
      .out_valid(tx_valid),
      .out_ready(tx_ready),
      .out_data(tx_data),
      .flush(flush_r)
   );
endmodule

/* testbench/uff_headend_model.sv */
// headend model: issues allocation map elements and sinks upstream payload bytes
`timescale 1ns/10ps
module uff_headend_model (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // allocation map toward the modem
   output logic map_valid,
   output logic [uff_pkg::SID_W-1:0] map_sid,
   output logic [uff_pkg::LEN_W-1:0] grant_bytes,
   output logic grant_pending,
   output logic later_grant_queued,
   // upstream bytes
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready,
   // bench control and observation
   input wire logic stall,
   output logic [uff_pkg::LEN_W-1:0] rx_count,
   output logic rx_bad
);
   import uff_pkg::*;
   // ====================================================
   // map element: one cycle, then fields scrambled so stale values never look valid
   initial begin
      map_valid = 1'b0;
      map_sid = '0;
      grant_bytes = '0;
      grant_pending = 1'b0;
      later_grant_queued = 1'b0;
   end
   task automatic send_map(input logic [SID_W-1:0] service_identifier, input logic [LEN_W-1:0] len, input logic pend,
      input logic later);
      @(negedge sys_clk);
      map_valid = 1'b1;
      map_sid = service_identifier;
      grant_bytes = len;
      grant_pending = pend;
      later_grant_queued = later;
      @(negedge sys_clk);
      map_valid = 1'b0;
      map_sid = ~service_identifier;
      grant_bytes = ~len;
      grant_pending = ~pend;
      later_grant_queued = ~later;
   endtask
   // ====================================================
   // byte sink: stalls on request, checks bytes arrive as a running count
   assign tx_ready = !stall;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_count <= '0;
         rx_bad <= 1'b0;
      end else if (tx_valid && tx_ready) begin
         rx_bad <= rx_bad | (tx_data !== rx_count[7:0]);
         rx_count <= rx_count + 16'h0001;
      end
   end
endmodule

/* testbench/uff_fragmenter_sva.sv */
// checker: fragment header and request properties at the fragmenter ports
`timescale 1ns/10ps
module uff_chk (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // frame, map and configuration
   input wire logic frame_immediate,
   input wire logic [uff_pkg::SID_W-1:0] frame_sid,
   input wire logic frame_done,
   input wire logic frame_dropped,
   input wire logic map_valid,
   input wire logic [uff_pkg::LEN_W-1:0] grant_bytes,
   input wire logic grant_pending,
   input wire logic later_grant_queued,
   input wire logic [uff_pkg::LEN_W-1:0] phy_ovh,
   // watched outputs
   input wire logic req_valid,
   input wire logic [uff_pkg::SID_W-1:0] req_sid,
   input wire logic hdr_valid,
   input wire logic [uff_pkg::SID_W-1:0] hdr_sid,
   input wire logic [1:0] hdr_flags,
   input wire logic [uff_pkg::SEQ_W-1:0] hdr_seq,
   input wire logic [uff_pkg::REQ_W-1:0] hdr_piggyback,
   input wire logic [uff_pkg::LEN_W-1:0] hdr_payload_len,
   input wire logic hdr_fragmented,
   input wire logic [uff_pkg::LEN_W-1:0] crypt_start
);
   import uff_pkg::*;
   // ====================================================
   // last fragment sequence number seen per flow
   logic [SEQ_W-1:0] seq_r [16];
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 16; i++) seq_r[i] <= '0;
      end else if (hdr_valid && hdr_fragmented) begin
         seq_r[hdr_sid] <= hdr_seq;
      end
   end
   default clocking dc @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // ====================================================
   // properties
   imm_no_frag_a: assert property (hdr_valid && frame_immediate |-> !hdr_fragmented)
      else $error("immediate frame was fragmented");
   flag_combo_a: assert property (hdr_valid && hdr_fragmented |-> hdr_flags != 2'b11)
      else $error("first and last flags both set");
   pend_no_pb_a: assert property ((map_valid && grant_bytes != '0 && grant_pending) ##1 hdr_valid
      |-> hdr_piggyback == 8'h00) else $error("piggyback sent beside a pending");
   queued_no_pb_a: assert property ((map_valid && grant_bytes != '0 && later_grant_queued) ##1 hdr_valid
      |-> hdr_piggyback == 8'h00) else $error("piggyback sent with grant queued");
   pb_present_a: assert property ((map_valid && !grant_pending && !later_grant_queued) ##1
      (hdr_valid && hdr_fragmented && !hdr_flags[FLG_LAST]) |-> hdr_piggyback != 8'h00)
      else $error("remainder not piggybacked");
   crypt_zero_a: assert property (hdr_valid && hdr_fragmented |-> crypt_start == '0)
      else $error("encryption offset not at header end");
   payload_fill_a: assert property (hdr_valid && hdr_fragmented && !hdr_flags[FLG_LAST]
      |-> hdr_payload_len == $past(grant_bytes) - FRAG_OVH - $past(phy_ovh)) else $error("grant not filled");
   seq_step_a: assert property (hdr_valid && hdr_fragmented && !hdr_flags[FLG_FIRST]
      |-> hdr_seq == seq_r[hdr_sid] + 4'h1) else $error("sequence did not advance by one");
   flow_match_a: assert property (req_valid || hdr_valid |-> req_sid == frame_sid || !req_valid)
      else $error("request for wrong flow");
   drop_quiet_a: assert property (frame_dropped |-> !frame_done && !hdr_valid)
      else $error("dropped frame still sent");
endmodule
bind uff_fragmenter uff_chk u_chk (.sys_clk, .rst_n, .frame_immediate, .frame_sid, .frame_done, .frame_dropped,
   .map_valid, .grant_bytes, .grant_pending, .later_grant_queued, .phy_ovh, .req_valid, .req_sid, .hdr_valid,
   .hdr_sid, .hdr_flags, .hdr_seq, .hdr_piggyback, .hdr_payload_len, .hdr_fragmented, .crypt_start);

/* testbench/testbench.sv */
// testbench: fragmenting, immediate-region and retry-drop cases for the fragmenter
`timescale 1ns/10ps
module testbench;
   import uff_pkg::*;
   // ====================================================
   // signals
   localparam int ACK_SIM = 100;
   logic sys_clk, rst_n, frag_en_modem, frame_valid, frame_immediate, next_frame_pending, frame_done, frame_dropped;
   logic map_valid, grant_pending, later_grant_queued, pay_valid, pay_ready, req_valid, hdr_valid, hdr_fragmented;
   logic tx_valid, tx_ready, stall, rx_bad, pay_take_r;
   logic [15:0] frag_en_flow;
   logic [LEN_W-1:0] phy_ovh, mslot_bytes, frame_len, next_frame_len, grant_bytes, hdr_payload_len, crypt_start;
   logic [LEN_W-1:0] rx_count;
   logic [RTY_W-1:0] retry_max;
   logic [SID_W-1:0] frame_sid, map_sid, req_sid, hdr_sid;
   logic [REQ_W-1:0] req_mslots, hdr_piggyback;
   logic [SEQ_W-1:0] hdr_seq, seq_prev;
   logic [1:0] hdr_flags;
   logic [7:0] pay_data, tx_data;
   int fail_count = 0;
   int checks_done = 0;
   int cyc = 0;
   int hdr_cnt = 0;
   uff_fragmenter #(.ACK_CYCLES(ACK_SIM)) dut (.sys_clk, .rst_n, .frag_en_modem, .frag_en_flow, .phy_ovh,
      .mslot_bytes, .retry_max, .frame_valid, .frame_sid, .frame_len, .frame_immediate, .next_frame_pending,
      .next_frame_len, .frame_done, .frame_dropped, .map_valid, .map_sid, .grant_bytes, .grant_pending,
      .later_grant_queued, .pay_valid, .pay_data, .pay_ready, .req_valid, .req_sid, .req_mslots, .hdr_valid,
      .hdr_sid, .hdr_flags, .hdr_seq, .hdr_piggyback, .hdr_payload_len, .hdr_fragmented, .crypt_start,
      .tx_valid, .tx_data, .tx_ready);
   uff_headend_model hm (.sys_clk, .rst_n, .map_valid, .map_sid, .grant_bytes, .grant_pending,
      .later_grant_queued, .tx_valid, .tx_data, .tx_ready, .stall, .rx_count, .rx_bad);
   // ====================================================
   // clock, hang guard, payload counter and header pulse count
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         test_done();
      end
   end
   // handshake seen at a falling edge completes at the next rising edge
   always @(negedge sys_clk) begin
      if (hdr_valid === 1'b1) hdr_cnt++;
      if (pay_take_r) pay_data <= pay_data + 8'h01;
      pay_take_r <= pay_valid && pay_ready === 1'b1;
   end
   // ====================================================
   // shared tasks
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // which: 0 request, 1 header, 2 frame done
   task automatic wait_for(input int which, input int lim);
      int n;
      logic hit;
      n = -1;
      hit = 1'b0;
      // first pass looks at a pulse already standing when the task is called
      while (!hit && n < lim) begin
         if (n >= 0) begin
            @(posedge sys_clk);
            #1;
         end
         n++;
         hit = (which == 0) ? req_valid === 1'b1 : (which == 1) ? hdr_valid === 1'b1 : frame_done === 1'b1;
      end
      check(hit, 1'b1);
   endtask
   task automatic hdr_chk(input logic [1:0] fl, input logic [15:0] len, input logic [7:0] pb);
      wait_for(1, 20);
      check(hdr_fragmented, 1'b1);
      check(hdr_flags, fl);
      check(hdr_payload_len, len);
      check(hdr_piggyback, pb);
      check(crypt_start, 16'h0000);
      check(hdr_sid, frame_sid);
      if (fl != 2'b10) check(hdr_seq, seq_prev + 4'h1);
      seq_prev = hdr_seq;
   endtask
   task automatic test_done();
      if (fail_count == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // ====================================================
   // scenarios
   // 176 bytes, phy 8, 16-byte slots: grants of 60 carry 36, remainders 140/104/68
   task automatic frag_scn();
      int h;
      @(negedge sys_clk);
      frame_sid = 4'h5;
      frame_len = 16'h00b0;
      next_frame_pending = 1'b1;
      next_frame_len = 16'h0028;
      stall = 1'b1;
      frame_valid = 1'b1;
      wait_for(0, 10);
      check(req_mslots, 8'h0c);
      check(req_sid, 4'h5);
      h = hdr_cnt;
      hm.send_map(4'h6, 16'h003c, 1'b0, 1'b0);
      repeat (4) @(posedge sys_clk);
      check(hdr_cnt - h, 0);
      hm.send_map(4'h5, 16'h003c, 1'b0, 1'b0);
      hdr_chk(2'b10, 16'h0024, 8'h0b);
      // sink stalled: the fifo fills and must refuse more payload
      repeat (30) @(negedge sys_clk);
      check(pay_ready, 1'b0);
      check(tx_valid, 1'b1);
      stall = 1'b0;
      // no grant: timeout and backoff, then the remainder is asked for again
      wait_for(0, 400);
      check(req_mslots, 8'h0b);
      hm.send_map(4'h5, 16'h003c, 1'b1, 1'b0);
      hdr_chk(2'b00, 16'h0024, 8'h00);
      repeat (50) @(negedge sys_clk);
      hm.send_map(4'h5, 16'h003c, 1'b0, 1'b1);
      hdr_chk(2'b00, 16'h0024, 8'h00);
      repeat (50) @(negedge sys_clk);
      hm.send_map(4'h5, 16'h0064, 1'b0, 1'b0);
      hdr_chk(2'b01, 16'h0044, 8'h03);
      wait_for(2, 400);
      @(negedge sys_clk);
      frame_valid = 1'b0;
      next_frame_pending = 1'b0;
      repeat (50) @(posedge sys_clk);
      check(rx_count, 16'h00b0);
      check(rx_bad, 1'b0);
   endtask
   // immediate-region frame: a short grant is not used to fragment it
   task automatic imm_scn();
      int h;
      @(negedge sys_clk);
      frag_en_flow = 16'h0004;
      frame_sid = 4'h2;
      frame_len = 16'h0028;
      frame_immediate = 1'b1;
      frame_valid = 1'b1;
      wait_for(0, 10);
      check(req_mslots, 8'h03);
      h = hdr_cnt;
      hm.send_map(4'h2, 16'h001e, 1'b0, 1'b0);
      repeat (4) @(posedge sys_clk);
      check(hdr_cnt - h, 0);
      hm.send_map(4'h2, 16'h0030, 1'b0, 1'b0);
      wait_for(1, 20);
      check(hdr_fragmented, 1'b0);
      check(hdr_payload_len, 16'h0028);
      wait_for(2, 200);
      @(negedge sys_clk);
      frame_valid = 1'b0;
      frame_immediate = 1'b0;
      repeat (20) @(posedge sys_clk);
      check(rx_count, 16'h00d8);
   endtask
   // never granted: one request plus two retries, then the frame is dropped
   task automatic drop_scn();
      int n;
      int reqs;
      logic hit;
      n = 0;
      reqs = 0;
      hit = 1'b0;
      @(negedge sys_clk);
      frame_sid = 4'h3;
      frame_valid = 1'b1;
      while (!hit && n < 1500) begin
         @(posedge sys_clk);
         #1;
         n++;
         if (req_valid === 1'b1) reqs++;
         hit = frame_dropped === 1'b1;
      end
      check(hit, 1'b1);
      check(reqs, 3);
      @(negedge sys_clk);
      frame_valid = 1'b0;
   endtask
   // ====================================================
   // main sequence
   initial begin
      rst_n = 1'b0;
      frag_en_modem = 1'b1;
      frag_en_flow = 16'hffff;
      phy_ovh = 16'h0008;
      mslot_bytes = 16'h0010;
      retry_max = 4'h2;
      frame_valid = 1'b0;
      frame_sid = '0;
      frame_len = 16'h0028;
      frame_immediate = 1'b0;
      next_frame_pending = 1'b0;
      next_frame_len = '0;
      pay_valid = 1'b1;
      pay_data = 8'h00;
      pay_take_r = 1'b0;
      stall = 1'b0;
      seq_prev = '0;
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      rst_n = 1'b1;
      frag_scn();
      imm_scn();
      drop_scn();
      test_done();
   end
endmodule
